// *** hdl/vic_defines.vh ***
// Constants for the vectored interrupt controller: word addresses, field
// layouts, reset values and priority encoding.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH

// ****************************************************************
// Channel counts and field widths
// ****************************************************************
`define VIC_NCH          64
`define VIC_NEXT         16
`define VIC_NINT         48
`define VIC_IDXW         6
`define VIC_LVLW         3
`define VIC_ADDRW        7
`define VIC_DW           32
`define VIC_PRI_STRIDE   4
`define VIC_PRI_PER_REG  8
`define VIC_EVW          2

// ****************************************************************
// Priority levels: 0..1 fast (0 highest), 2..7 normal (2 highest)
// ****************************************************************
`define VIC_FAST_LEVELS  3'h2
`define VIC_PRI_RST      3'h7

// ****************************************************************
// Word addresses on the register bus
// ****************************************************************
`define VIC_A_PEND_LO    7'h00
`define VIC_A_PEND_HI    7'h01
`define VIC_A_EN_LO      7'h02
`define VIC_A_EN_HI      7'h03
`define VIC_A_PRI0       7'h04
`define VIC_A_PRI7       7'h0b
`define VIC_A_FENTRY     7'h0c
`define VIC_A_NENTRY     7'h0d
`define VIC_A_WIN        7'h0e
`define VIC_A_ISTAT      7'h0f
`define VIC_A_IMASK      7'h10
`define VIC_TBL_BIT      6

// ****************************************************************
// Winner register fields and interrupt event bits
// ****************************************************************
`define VIC_WIN_FIDX     0
`define VIC_WIN_FVAL     6
`define VIC_WIN_NIDX     8
`define VIC_WIN_NVAL     14
`define VIC_EV_FAST      0
`define VIC_EV_NORM      1

// ****************************************************************
// Reset values
// ****************************************************************
`define VIC_ZERO32       32'h0000_0000
`define VIC_EN_RST       32'h0000_0000

`endif

// *** hdl/vic_prio_sel.v ***
// Priority selector: picks the requesting channel with the lowest level
// number; among equal levels the lowest channel index wins.
// Assumes purely combinational use on the caller's clock.
`timescale 1ns/1ns
`default_nettype none
`include "vic_defines.vh"

module vic_prio_sel #(
   parameter N   = 64,
   parameter LW  = 3,
   parameter IW  = 6
) (
   input  wire [N-1:0]    req,       // Qualified requests
   input  wire [N*LW-1:0] lvl_flat,  // Level of each channel
   output reg             valid,     // Any request present
   output reg  [IW-1:0]   idx,       // Winning channel
   output reg  [LW-1:0]   lvl        // Winning level
);

   integer c;

   // ****************************************************************
   // Comparison chain
   // ****************************************************************
   // Scanning downward with <= lets the lowest index win a tie
   always @* begin
      valid = 1'b0;
      idx   = {IW{1'b0}};
      lvl   = {LW{1'b1}};
      for (c = N - 1; c >= 0; c = c - 1) begin
         if (req[c] && (!valid || lvl_flat[c*LW +: LW] <= lvl)) begin
            valid = 1'b1;
            idx   = c[IW-1:0];
            lvl   = lvl_flat[c*LW +: LW];
         end
      end
   end

endmodule
`default_nettype wire

// *** hdl/vic_ctrl.v ***
// Vectored interrupt controller: 64 pending channels, per-channel enable,
// priority level that also routes to the fast or normal request, and a
// per-channel service-routine entry table.
// Assumes an Avalon-MM master on clk, internal sources on clk, and
// external pins asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "vic_defines.vh"

// Behaviour
// - Sixty-four channels, sixteen from external pins
// - Per-channel enable; disabled channels never request
// - Each channel routed to fast or normal
// - Hardware compares priorities of simultaneous requests
// - Two fast levels, six normal levels
// - Software-writable entry address table
// - Entry register takes highest-priority channel's address
module vic_ctrl (
   input  wire                   clk,                      // System clock, 20 MHz
   input  wire                   rst_n,                    // Asynchronous reset, active low
   input  wire [`VIC_ADDRW-1:0]  avs_address,              // Word address
   input  wire                   avs_read,                 // Read request
   input  wire                   avs_write,                // Write request
   input  wire [`VIC_DW-1:0]     avs_writedata,            // Write data
   output reg  [`VIC_DW-1:0]     avs_readdata,             // Read data
   output reg                    avs_waitrequest,          // Stall, high when idle
   input  wire [`VIC_NINT-1:0]   int_src,                  // On-chip sources, clk domain
   input  wire [`VIC_NEXT-1:0]   ext_pin,                  // External sources, asynchronous
   output reg                    fast_interrupt_request,   // Fast request to core
   output reg                    normal_interrupt_request, // Normal request to core
   output reg                    ctrl_irq                  // Controller's own interrupt
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   reg  [`VIC_NEXT-1:0]  ext_s1_r;
   reg  [`VIC_NEXT-1:0]  ext_s2_r;
   reg  [`VIC_NCH-1:0]   pend_r;
   reg  [`VIC_NCH-1:0]   pend_nxt;
   reg  [`VIC_NCH-1:0]   en_r;
   reg  [`VIC_LVLW-1:0]  pri_r [0:`VIC_NCH-1];
   reg  [`VIC_DW-1:0]    tbl_r [0:`VIC_NCH-1];
   reg  [`VIC_DW-1:0]    fentry_r;
   reg  [`VIC_DW-1:0]    nentry_r;
   reg  [`VIC_IDXW-1:0]  fidx_r;
   reg  [`VIC_IDXW-1:0]  nidx_r;
   reg  [`VIC_EVW-1:0]   istat_r;
   reg  [`VIC_EVW-1:0]   istat_nxt;
   reg  [`VIC_EVW-1:0]   imask_r;
   reg  [`VIC_DW-1:0]    rdata_nxt;
   reg  [`VIC_NCH-1:0]   clr_pend;
   wire [`VIC_NCH-1:0]   src_all;
   wire [`VIC_NCH-1:0]   active;
   wire [`VIC_NCH-1:0]   is_fast;
   wire [`VIC_NCH-1:0]   freq;
   wire [`VIC_NCH-1:0]   nreq;
   wire [`VIC_NCH*`VIC_LVLW-1:0] lvl_flat;
   wire                  f_valid;
   wire [`VIC_IDXW-1:0]  f_idx;
   wire                  n_valid;
   wire [`VIC_IDXW-1:0]  n_idx;
   wire                  bus_req;
   wire                  xfer_wr;
   wire                  take_rd;
   wire [`VIC_ADDRW-1:0] pri_off;
   wire                  in_tbl;
   wire                  in_pri;
   wire [`VIC_IDXW-1:0]  tbl_idx;
   wire [`VIC_EVW-1:0]   ev_set;
   wire                  wr_pend_lo;
   wire                  wr_pend_hi;
   wire                  wr_en_lo;
   wire                  wr_en_hi;
   wire                  wr_pri;
   wire                  wr_tbl;
   wire                  wr_istat;
   wire                  wr_imask;
   wire [`VIC_EVW-1:0]   imask_nxt;
   integer               c;
   integer               k;

   // ****************************************************************
   // Source capture
   // ****************************************************************
   // external pins synchronised
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_s1_r <= {`VIC_NEXT{1'b0}};
         ext_s2_r <= {`VIC_NEXT{1'b0}};
      end else begin
         ext_s1_r <= ext_pin;
         ext_s2_r <= ext_s1_r;
      end
   end

   assign src_all = {ext_s2_r, int_src};

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   // One wait state: the request is seen with waitrequest high, then
   // completes on the following edge with waitrequest low.
   assign bus_req = avs_read | avs_write;
   assign xfer_wr = avs_write & ~avs_waitrequest;
   assign take_rd = avs_read & avs_waitrequest;
   assign pri_off = avs_address - `VIC_A_PRI0;
   assign in_pri  = (avs_address >= `VIC_A_PRI0) && (avs_address <= `VIC_A_PRI7);
   assign in_tbl  = avs_address[`VIC_TBL_BIT];
   assign tbl_idx = avs_address[`VIC_IDXW-1:0];

   // ****************************************************************
   // Write strobes
   // ****************************************************************
   // Each strobe is true on the completing edge of a write only
   assign wr_pend_lo = xfer_wr && (avs_address == `VIC_A_PEND_LO);
   assign wr_pend_hi = xfer_wr && (avs_address == `VIC_A_PEND_HI);
   assign wr_en_lo   = xfer_wr && (avs_address == `VIC_A_EN_LO);
   assign wr_en_hi   = xfer_wr && (avs_address == `VIC_A_EN_HI);
   assign wr_pri     = xfer_wr && in_pri;
   assign wr_tbl     = xfer_wr && in_tbl;
   assign wr_istat   = xfer_wr && (avs_address == `VIC_A_ISTAT);
   assign wr_imask   = xfer_wr && (avs_address == `VIC_A_IMASK);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~(bus_req & avs_waitrequest);
      end
   end

   // ****************************************************************
   // Pending flags
   // ****************************************************************
   always @* begin
      clr_pend = {`VIC_NCH{1'b0}};
      if (wr_pend_lo) begin
         clr_pend[`VIC_DW-1:0] = avs_writedata;
      end
      if (wr_pend_hi) begin
         clr_pend[`VIC_NCH-1:`VIC_DW] = avs_writedata;
      end
      // A source asserted in the clearing cycle keeps its flag set
      pend_nxt = (pend_r & ~clr_pend) | src_all;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= {`VIC_NCH{1'b0}};
      end else begin
         pend_r <= pend_nxt;
      end
   end

   // ****************************************************************
   // Enables, priorities and entry table
   // ****************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en_r <= {`VIC_EN_RST, `VIC_EN_RST};
         for (c = 0; c < `VIC_NCH; c = c + 1) begin
            pri_r[c] <= `VIC_PRI_RST;
            tbl_r[c] <= `VIC_ZERO32;
         end
      end else begin
         if (wr_en_lo) begin
            en_r[`VIC_DW-1:0] <= avs_writedata;
         end
         if (wr_en_hi) begin
            en_r[`VIC_NCH-1:`VIC_DW] <= avs_writedata;
         end
         for (c = 0; c < `VIC_NCH; c = c + 1) begin
            if (wr_pri && c[5:3] == pri_off[2:0]) begin
               pri_r[c] <= avs_writedata[c[2:0]*`VIC_PRI_STRIDE +: `VIC_LVLW];
            end
         end
         if (wr_tbl) begin
            tbl_r[tbl_idx] <= avs_writedata;
         end
      end
   end

   // ****************************************************************
   // Qualification and routing
   // ****************************************************************
   // enable gates each channel
   assign active = pend_r & en_r;

   genvar g;
   generate
      for (g = 0; g < `VIC_NCH; g = g + 1) begin : g_route
         assign is_fast[g] = (pri_r[g] < `VIC_FAST_LEVELS);
         assign lvl_flat[g*`VIC_LVLW +: `VIC_LVLW] = pri_r[g];
      end
   endgenerate

   assign freq = active & is_fast;
   assign nreq = active & ~is_fast;

   vic_prio_sel #(
      .N   (`VIC_NCH),
      .LW  (`VIC_LVLW),
      .IW  (`VIC_IDXW)
   ) u_fast_sel (
      .req       (freq),
      .lvl_flat  (lvl_flat),
      .valid     (f_valid),
      .idx       (f_idx),
      .lvl       ()
   );

   vic_prio_sel #(
      .N   (`VIC_NCH),
      .LW  (`VIC_LVLW),
      .IW  (`VIC_IDXW)
   ) u_norm_sel (
      .req       (nreq),
      .lvl_flat  (lvl_flat),
      .valid     (n_valid),
      .idx       (n_idx),
      .lvl       ()
   );

   // ****************************************************************
   // Requests and entry registers
   // ****************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_interrupt_request   <= 1'b0;
         normal_interrupt_request <= 1'b0;
         fentry_r <= `VIC_ZERO32;
         nentry_r <= `VIC_ZERO32;
         fidx_r   <= {`VIC_IDXW{1'b0}};
         nidx_r   <= {`VIC_IDXW{1'b0}};
      end else begin
         fast_interrupt_request   <= f_valid;
         normal_interrupt_request <= n_valid;
         // winner's address loaded
         // Entry holds its last value once no channel is active, so a
         // late read by the handler still sees the vector it was raised for.
         if (f_valid) begin
            fentry_r <= tbl_r[f_idx];
            fidx_r   <= f_idx;
         end
         if (n_valid) begin
            nentry_r <= tbl_r[n_idx];
            nidx_r   <= n_idx;
         end
      end
   end

   // ****************************************************************
   // Controller's own interrupt
   // ****************************************************************
   assign ev_set[`VIC_EV_FAST] = f_valid & ~fast_interrupt_request;
   assign ev_set[`VIC_EV_NORM] = n_valid & ~normal_interrupt_request;

   // ****************************************************************
   // Status and mask
   // ****************************************************************
   // A mask written this edge counts at once, so the irq never lags it
   assign imask_nxt = wr_imask ? avs_writedata[`VIC_EVW-1:0] : imask_r;

   always @* begin
      istat_nxt = istat_r;
      if (wr_istat) begin
         istat_nxt = istat_nxt & ~avs_writedata[`VIC_EVW-1:0];
      end
      istat_nxt = istat_nxt | ev_set;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         istat_r  <= {`VIC_EVW{1'b0}};
         imask_r  <= {`VIC_EVW{1'b0}};
         ctrl_irq <= 1'b0;
      end else begin
         istat_r  <= istat_nxt;
         if (wr_imask) begin
            imask_r <= avs_writedata[`VIC_EVW-1:0];
         end
         ctrl_irq <= |(istat_nxt & imask_nxt);
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************
   // handler reads entry register
   always @* begin
      rdata_nxt = `VIC_ZERO32;
      if (in_tbl) begin
         rdata_nxt = tbl_r[tbl_idx];
      end else if (in_pri) begin
         for (k = 0; k < `VIC_NCH; k = k + 1) begin
            if (k[5:3] == pri_off[2:0]) begin
               rdata_nxt[k[2:0]*`VIC_PRI_STRIDE +: `VIC_LVLW] = pri_r[k];
            end
         end
      end else begin
         case (avs_address)
            `VIC_A_PEND_LO: rdata_nxt = pend_r[`VIC_DW-1:0];
            `VIC_A_PEND_HI: rdata_nxt = pend_r[`VIC_NCH-1:`VIC_DW];
            `VIC_A_EN_LO:   rdata_nxt = en_r[`VIC_DW-1:0];
            `VIC_A_EN_HI:   rdata_nxt = en_r[`VIC_NCH-1:`VIC_DW];
            `VIC_A_FENTRY:  rdata_nxt = fentry_r;
            `VIC_A_NENTRY:  rdata_nxt = nentry_r;
            `VIC_A_WIN: begin
               rdata_nxt[`VIC_WIN_FIDX +: `VIC_IDXW] = fidx_r;
               rdata_nxt[`VIC_WIN_FVAL]              = fast_interrupt_request;
               rdata_nxt[`VIC_WIN_NIDX +: `VIC_IDXW] = nidx_r;
               rdata_nxt[`VIC_WIN_NVAL]              = normal_interrupt_request;
            end
            `VIC_A_ISTAT:   rdata_nxt[`VIC_EVW-1:0] = istat_r;
            `VIC_A_IMASK:   rdata_nxt[`VIC_EVW-1:0] = imask_r;
            default:        rdata_nxt = `VIC_ZERO32;
         endcase
      end
   end

   // Data is captured while waitrequest is high, so it is already stable
   // on the completing edge.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= `VIC_ZERO32;
      end else if (take_rd) begin
         avs_readdata <= rdata_nxt;
      end
   end

endmodule
`default_nettype wire

// *** testbench/vic_ctrl_properties.sv ***
// Checker: bus handshake, read data hold, request and status drops.
// Assumes a bind to vic_ctrl; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module vic_ctrl_properties (
   input wire logic        clk,                      // Clock
   input wire logic        rst_n,                    // Reset
   input wire logic        avs_read,                 // Read
   input wire logic        avs_write,                // Write
   input wire logic [31:0] avs_readdata,             // Read data
   input wire logic        avs_waitrequest,          // Stall
   input wire logic        fast_interrupt_request,   // Fast request
   input wire logic        normal_interrupt_request, // Normal request
   input wire logic        ctrl_irq                  // Status interrupt
);
   // Enable and level change, and pending and status clear, only through a completed write
   wire wr_done = avs_write && !avs_waitrequest;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ****************
   // Bus handshake
   // ****************
   sequence s_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   AST_BUS_ANSWER: assert property (s_taken |=> s_answer)
      else $error("access without a single wait cycle");
   AST_BUS_IDLE: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
      else $error("wait dropped while idle");
   AST_BUS_CAUSE: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
      else $error("wait dropped without a request");
   AST_RDATA_HOLD: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
      else $error("read data moved outside a read");
   // ****************
   // Requests and status
   // ****************
   AST_FAST_DROP: assert property ($fell(fast_interrupt_request) |-> $past(wr_done) || $past(wr_done, 2))
      else $error("fast request dropped with channels untouched");
   AST_NORM_DROP: assert property ($fell(normal_interrupt_request) |-> $past(wr_done) || $past(wr_done, 2))
      else $error("normal request dropped with channels untouched");
   AST_IRQ_RISE: assert property ($rose(ctrl_irq) |-> $rose(fast_interrupt_request)
      || $rose(normal_interrupt_request) || $past(wr_done) || $past(wr_done, 2))
      else $error("status interrupt rose without cause");
   AST_IRQ_FALL: assert property ($fell(ctrl_irq) |-> $past(wr_done) || $past(wr_done, 2))
      else $error("status interrupt fell without a write");
endmodule
bind vic_ctrl vic_ctrl_properties u_vic_ctrl_properties (
   .clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .fast_interrupt_request(fast_interrupt_request),
   .normal_interrupt_request(normal_interrupt_request), .ctrl_irq(ctrl_irq));
`default_nettype wire

// *** testbench/vic_core_model.sv ***
// Core model: takes a request once it has stood one cycle, or four when slow.
// Assumes the controller's request outputs on the same clock.
`timescale 1ns/1ns
`default_nettype none
module vic_core_model (
   input  wire logic clk,       // Clock
   input  wire logic rst_n,     // Reset, active low
   input  wire logic slow,      // Slow answer
   input  wire logic fast_req,  // Fast request
   input  wire logic norm_req,  // Normal request
   output var  logic fast_take, // Fast request taken
   output var  logic norm_take  // Normal request taken
);
   logic [2:0] fast_cnt_r;
   logic [2:0] norm_cnt_r;
   logic [2:0] need;
   // Counters saturate so a long request never wraps to "not taken"
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fast_cnt_r <= 3'h0;
         norm_cnt_r <= 3'h0;
      end else begin
         fast_cnt_r <= fast_req ? fast_cnt_r + {2'h0, fast_cnt_r != 3'h7} : 3'h0;
         norm_cnt_r <= norm_req ? norm_cnt_r + {2'h0, norm_cnt_r != 3'h7} : 3'h0;
      end
   end
   always_comb begin
      need = slow ? 3'h4 : 3'h1;
      fast_take = fast_req && fast_cnt_r >= need;
      norm_take = norm_req && norm_cnt_r >= need;
   end
endmodule
`default_nettype wire

// *** testbench/test_vectored_interrupt_controller.sv ***
// Bench: routing table per level, then masking, priority, ties and reset.
// Assumes the design headers on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "vic_defines.vh"
module test_vectored_interrupt_controller;
   typedef struct packed {logic [5:0] ch; logic [2:0] lvl; logic [31:0] entry;} vic_row_t;
   logic                  clk;
   logic                  rst_n;
   logic [`VIC_ADDRW-1:0] avs_address;
   logic                  avs_read;
   logic                  avs_write;
   logic [`VIC_DW-1:0]    avs_writedata;
   wire  [`VIC_DW-1:0]    avs_readdata;
   wire                   avs_waitrequest;
   logic [`VIC_NINT-1:0]  int_src;
   logic [`VIC_NEXT-1:0]  ext_pin;
   wire                   fast_interrupt_request;
   wire                   normal_interrupt_request;
   wire                   ctrl_irq;
   wire                   fast_take;
   wire                   norm_take;
   logic                  slow;
   logic                  fast_exp;
   logic [31:0]           rd;
   int                    n_fail;
   int                    total_checks;
   vic_row_t              rows [8];
   vic_row_t              r;
   vic_ctrl u_vic_ctrl (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .int_src(int_src), .ext_pin(ext_pin),
      .fast_interrupt_request(fast_interrupt_request), .normal_interrupt_request(normal_interrupt_request),
      .ctrl_irq(ctrl_irq));
   vic_core_model u_vic_core_model (.clk(clk), .rst_n(rst_n), .slow(slow), .fast_req(fast_interrupt_request),
      .norm_req(normal_interrupt_request), .fast_take(fast_take), .norm_take(norm_take));
   always #25 clk = ~clk;
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic hang(input string what);
      n_fail++;
      $display("ERROR %0t no answer on %s", $time, what);
      summarize();
   endtask
   // One access; the request stands until wait is seen low
   task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) hang("bus");
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic fire(input logic [63:0] m);
      @(posedge clk);
      int_src <= m[47:0];
      ext_pin <= m[63:48];
      @(posedge clk);
      int_src <= '0;
      ext_pin <= '0;
   endtask
   task automatic wait_take(input logic fast);
      int n;
      n = 0;
      while ((fast ? fast_take : norm_take) !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40) hang("request");
   endtask
   function automatic logic [31:0] pri_word(input logic [2:0] slot, input logic [2:0] lvl);
      pri_word = 32'h7777_7777;
      pri_word[slot*4 +: 3] = lvl;
   endfunction
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      avs_address = 7'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      int_src = '0;
      ext_pin = '0;
      slow = 1'b0;
      n_fail = 0;
      total_checks = 0;
      rows = '{'{6'h00, 3'h0, 32'h1000}, '{6'h2f, 3'h1, 32'h12f0}, '{6'h30, 3'h2, 32'h1300},
         '{6'h3f, 3'h3, 32'h13f0}, '{6'h0c, 3'h4, 32'h10c0}, '{6'h21, 3'h5, 32'h1210},
         '{6'h37, 3'h6, 32'h1370}, '{6'h14, 3'h7, 32'h1140}};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, 7'h04, 32'h0);
      chk(rd, 32'h7777_7777, "level reset");
      bus(1'b1, 7'h20, 32'hffff_ffff);
      bus(1'b0, 7'h20, 32'h0);
      chk(rd, 32'h0, "unmapped");
      foreach (rows[i]) begin
         r = rows[i];
         fast_exp = r.lvl < 3'h2;
         slow <= i[0];
         bus(1'b1, 7'h40 + {1'b0, r.ch}, r.entry);
         bus(1'b1, 7'h04 + {4'h0, r.ch[5:3]}, pri_word(r.ch[2:0], r.lvl));
         bus(1'b1, r.ch[5] ? 7'h03 : 7'h02, 32'h1 << r.ch[4:0]);
         fire(64'h1 << r.ch);
         wait_take(fast_exp);
         chk(fast_interrupt_request, fast_exp, "fast route");
         chk(normal_interrupt_request, !fast_exp, "normal route");
         bus(1'b0, fast_exp ? 7'h0c : 7'h0d, 32'h0);
         chk(rd, r.entry, "entry");
         bus(1'b1, r.ch[5] ? 7'h01 : 7'h00, 32'h1 << r.ch[4:0]);
         repeat (2) @(posedge clk);
         chk({fast_interrupt_request, normal_interrupt_request}, 32'h0, "drop");
         bus(1'b1, r.ch[5] ? 7'h03 : 7'h02, 32'h0);
         bus(1'b1, 7'h04 + {4'h0, r.ch[5:3]}, 32'h7777_7777);
      end
      bus(1'b1, 7'h10, 32'h2);
      bus(1'b1, 7'h49, 32'h2090);
      bus(1'b1, 7'h05, pri_word(3'h1, 3'h2));
      bus(1'b1, 7'h04, pri_word(3'h5, 3'h3));
      bus(1'b1, 7'h09, pri_word(3'h0, 3'h3));
      bus(1'b1, 7'h02, 32'h220);
      fire(64'h0100_0000_0000);
      repeat (6) @(posedge clk);
      chk(normal_interrupt_request, 1'b0, "disabled channel");
      fire(64'h220);
      wait_take(1'b0);
      bus(1'b0, 7'h0e, 32'h0);
      chk(rd & 32'h7f00, 32'h4900, "winner");
      bus(1'b0, 7'h0d, 32'h0);
      chk(rd, 32'h2090, "winner entry");
      chk(ctrl_irq, 1'b1, "status irq");
      bus(1'b1, 7'h00, 32'h200);
      bus(1'b1, 7'h03, 32'h100);
      bus(1'b0, 7'h0e, 32'h0);
      chk(rd & 32'h7f00, 32'h4500, "tie");
      bus(1'b1, 7'h00, 32'h20);
      bus(1'b0, 7'h0e, 32'h0);
      chk(rd & 32'h7f00, 32'h6800, "last left");
      bus(1'b1, 7'h0f, 32'h2);
      bus(1'b1, 7'h01, 32'h100);
      repeat (2) @(posedge clk);
      chk({ctrl_irq, normal_interrupt_request}, 32'h0, "all quiet");
      bus(1'b1, 7'h02, 32'h1);
      fire(64'h1);
      wait_take(1'b0);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(normal_interrupt_request, 1'b0, "reset drop");
      rst_n <= 1'b1;
      bus(1'b0, 7'h00, 32'h0);
      chk(rd, 32'h0, "pending reset");
      summarize();
   end
endmodule
`default_nettype wire
